// ===== design/vpsc_defs.svh
// Register map, field positions, reset values and timing counts of the pin select block
`ifndef VPSC_DEFS_SVH
`define VPSC_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define VPSC_OFS_DIGIT_CTRL 8'h00
`define VPSC_OFS_SEG_CTRL 8'h04
`define VPSC_OFS_DIGIT_START 8'h08
`define VPSC_OFS_STATUS 8'h0c

// ****************************************
// Reset values
// ****************************************
`define VPSC_RST_DIGIT_CTRL 8'h00
`define VPSC_RST_SEG_CTRL 8'h20
`define VPSC_RST_DIGIT_START 8'h20

// ****************************************
// Field positions
// ****************************************
`define VPSC_DC_RATE_BIT 7
`define VPSC_DC_WAVE_MSB 6
`define VPSC_DC_WAVE_LSB 4
`define VPSC_DC_COUNT_MSB 3
`define VPSC_DC_COUNT_LSB 0
`define VPSC_SC_FLAG_BIT 7
`define VPSC_SC_KEY_BIT 6
`define VPSC_SC_RSVD_BIT 5
`define VPSC_SC_COUNT_MSB 4
`define VPSC_SC_COUNT_LSB 0
`define VPSC_DS_RUN_BIT 7
`define VPSC_DS_DISP_BIT 6
`define VPSC_DS_RSVD_BIT 5
`define VPSC_DS_SPARE_BIT 4
`define VPSC_DS_FIELD_MSB 3
`define VPSC_DS_FIELD_LSB 0

// ****************************************
// Timing counts in system clocks, steps per slot, and pin and code limits
// ****************************************
`define VPSC_SLOT_CLKS_SLOW 11'd1536
`define VPSC_STEP_CLKS_SLOW 7'd96
`define VPSC_SLOT_CLKS_FAST 11'd768
`define VPSC_STEP_CLKS_FAST 7'd48
`define VPSC_STEPS_PER_SLOT 5'd16
`define VPSC_SEG_MAX_CODE 5'd27
`define VPSC_SHARED_PINS 5'd8
`define VPSC_DIGIT_LAST 5'd15

`endif

// ===== design/vpsc_pkg.sv
// Types shared by the pin select block
`default_nettype none
package vpsc_pkg;
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_READ_WAIT
  } vpsc_bus_state_t;
  typedef logic [7:0] vpsc_byte_t;
endpackage : vpsc_pkg
`default_nettype wire

// ===== design/vpsc_ahb_slave.sv
// AHB-Lite slave front end: writes with no wait, reads with one wait state
`default_nettype none
`include "vpsc_defs.svh"
module vpsc_ahb_slave (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic hsel_in,
  input wire logic [7:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [31:0] rd_word_in,
  output logic [7:0] rd_addr_out,
  output logic wr_en_out,
  output logic [7:0] wr_addr_out,
  output logic [7:0] wr_data_out,
  output logic hreadyout_out,
  output logic [31:0] hrdata_out,
  output logic hresp_out
);
  import vpsc_pkg::*;

  vpsc_bus_state_t state;
  logic addr_take;
  logic wr_pend;
  logic [7:0] wr_addr_q;

  assign addr_take = hsel_in && htrans_in[1] && hready_in;
  assign rd_addr_out = wr_addr_q;
  assign wr_en_out = wr_pend;
  assign wr_addr_out = wr_addr_q;
  assign wr_data_out = hwdata_in[7:0];
  assign hresp_out = 1'b0;

  // ****************************************
  // Address phase capture
  // ****************************************
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_addr_q <= 8'h00;
      wr_pend <= 1'b0;
    end else begin
      wr_pend <= addr_take && hwrite_in;
      if (addr_take) begin
        wr_addr_q <= {haddr_in[7:2], 2'b00};
      end
    end
  end

  // ****************************************
  // Read wait state and read data
  // ****************************************
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= BUS_IDLE;
      hreadyout_out <= 1'b1;
      hrdata_out <= 32'h0000_0000;
    end else begin
      unique case (state)
        BUS_IDLE: begin
          if (addr_take && !hwrite_in) begin
            state <= BUS_READ_WAIT;
            hreadyout_out <= 1'b0;
          end
        end
        BUS_READ_WAIT: begin
          // Sampled a cycle late so a write just before is already visible
          hrdata_out <= rd_word_in;
          hreadyout_out <= 1'b1;
          state <= BUS_IDLE;
        end
      endcase
    end
  end
endmodule : vpsc_ahb_slave
`default_nettype wire

// ===== design/vpsc_slot_timer.sv
// Slot timer: dimmer steps within a digit slot, slot end pulse
`default_nettype none
`include "vpsc_defs.svh"
module vpsc_slot_timer (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic run_in,
  input wire logic fast_in,
  output logic [3:0] step_out,
  output logic slot_end_out
);
  import vpsc_pkg::*;

  logic [6:0] step_clks;
  logic [6:0] clk_cnt;
  logic step_end;

  assign step_clks = fast_in ? `VPSC_STEP_CLKS_FAST : `VPSC_STEP_CLKS_SLOW;
  assign step_end = (clk_cnt == step_clks - 7'd1);

  // ****************************************
  // Step and slot counting
  // ****************************************
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      clk_cnt <= 7'd0;
      step_out <= 4'd0;
      slot_end_out <= 1'b0;
    end else if (!run_in) begin
      clk_cnt <= 7'd0;
      step_out <= 4'd0;
      slot_end_out <= 1'b0;
    end else begin
      slot_end_out <= step_end && (step_out == 4'hf);
      if (step_end || clk_cnt >= step_clks) begin
        clk_cnt <= 7'd0;
        step_out <= step_out + 4'd1;
      end else begin
        clk_cnt <= clk_cnt + 7'd1;
      end
    end
  end
endmodule : vpsc_slot_timer
`default_nettype wire

// ===== design/vpsc_top.sv
// Display pin selection, frame sequencing and register file of the display driver
// Function
// R1: Digit count code c enables digit outputs 0 to 15-c; code 0 (reset) enables all sixteen.
// R2: Segment count code N enables segment outputs 0 to N for N up to 27; 28 to 31 enable none.
// R3: Segment control is 8 bits: flag 7, key scan allow 6, reserved 5, count 4:0, reset 8'h20.
// R4: Segment control bit 5 always reads one and ignores writes.
// R5: With the pin function flag clear (reset) every shared pin is a general-purpose port.
// R6: With the flag set pins follow the digit count, segment count and start field together.
// R7: In a key scan slot segment pins turn to port use and the flag reads as zero.
// R8: Key scan allow clear adds no slot; set allows one extra digit-time slot per frame.
// R9: The key scan slot is added only if the digit, segment and start settings leave both in use.
// R10: Digit control bits 6:4 select the digit strobe waveform.
// R11: Each waveform code fixes the digit and segment edges in dimmer steps within a slot; the code moves only the digit edge, segments always span steps 1 to 15.
// R12: Scan rate bit 0 gives 1536-clock slots and 96-clock steps; 1 gives 768 and 48.
// R13: A frame lasts one slot per digit in use plus one slot when key scanning is active.
// R14: Digit control is 8 bits, fully read/write, reset to zero.
`default_nettype none
`include "vpsc_defs.svh"
module vpsc_top #(
  parameter int DIGITS = 16,
  parameter int SEGMENTS = 28
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic hsel_in,
  input wire logic [7:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic [31:0] hrdata_out,
  output logic hresp_out,
  input wire logic [SEGMENTS-1:0] seg_data_in,
  output logic [3:0] digit_index_out,
  output logic [DIGITS-1:0] digit_output_out,
  output logic [DIGITS-1:0] digit_pin_display_out,
  output logic [SEGMENTS-1:0] segment_output_out,
  output logic [SEGMENTS-1:0] segment_pin_display_out,
  output logic key_scan_out
);
  import vpsc_pkg::*;

  // ****************************************
  // Registers and bus
  // ****************************************
  vpsc_pkg::vpsc_byte_t digit_control_reg;
  vpsc_pkg::vpsc_byte_t segment_control_reg;
  vpsc_pkg::vpsc_byte_t digit_start_reg;
  logic [7:0] rd_addr;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [31:0] rd_word;
  logic [31:0] hrdata_w;
  logic hreadyout_w;
  logic hresp_w;

  vpsc_ahb_slave u_bus (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .hsel_in(hsel_in),
    .haddr_in(haddr_in),
    .htrans_in(htrans_in),
    .hwrite_in(hwrite_in),
    .hsize_in(hsize_in),
    .hwdata_in(hwdata_in),
    .hready_in(hready_in),
    .rd_word_in(rd_word),
    .rd_addr_out(rd_addr),
    .wr_en_out(wr_en),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .hreadyout_out(hreadyout_w),
    .hrdata_out(hrdata_w),
    .hresp_out(hresp_w)
  );

  assign hreadyout_out = hreadyout_w;
  assign hrdata_out = hrdata_w;

  // ****************************************
  // Bus response
  // ****************************************
  // Always OKAY, yet kept in a flop like every other output
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hresp_out <= 1'b0;
    end else begin
      hresp_out <= hresp_w;
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      digit_control_reg <= `VPSC_RST_DIGIT_CTRL; // R14
    end else if (wr_en && wr_addr == `VPSC_OFS_DIGIT_CTRL) begin
      digit_control_reg <= wr_data; // R14
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      segment_control_reg <= `VPSC_RST_SEG_CTRL; // R3
    end else if (wr_en && wr_addr == `VPSC_OFS_SEG_CTRL) begin
      segment_control_reg <= wr_data | (8'h01 << `VPSC_SC_RSVD_BIT); // R4
    end
  end

  // Run bit gates the scan, display bit only the segment drive; the spare bit is plain storage
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      digit_start_reg <= `VPSC_RST_DIGIT_START;
    end else if (wr_en && wr_addr == `VPSC_OFS_DIGIT_START) begin
      digit_start_reg <= wr_data | (8'h01 << `VPSC_DS_RSVD_BIT);
    end
  end

  // ****************************************
  // Field decode
  // ****************************************
  logic scan_rate_select;
  logic [2:0] digit_waveform_select;
  logic [3:0] digit_count_field;
  logic pin_function_flag;
  logic key_scan_allow;
  logic [4:0] segment_count_field;
  logic [3:0] dual_pin_start_field;
  logic run;
  logic disp;

  assign scan_rate_select = digit_control_reg[`VPSC_DC_RATE_BIT];
  assign digit_waveform_select = digit_control_reg[`VPSC_DC_WAVE_MSB:`VPSC_DC_WAVE_LSB]; // R10
  assign digit_count_field = digit_control_reg[`VPSC_DC_COUNT_MSB:`VPSC_DC_COUNT_LSB];
  assign pin_function_flag = segment_control_reg[`VPSC_SC_FLAG_BIT];
  assign key_scan_allow = segment_control_reg[`VPSC_SC_KEY_BIT];
  assign segment_count_field = segment_control_reg[`VPSC_SC_COUNT_MSB:`VPSC_SC_COUNT_LSB];
  assign dual_pin_start_field = digit_start_reg[`VPSC_DS_FIELD_MSB:`VPSC_DS_FIELD_LSB];
  assign run = digit_start_reg[`VPSC_DS_RUN_BIT];
  assign disp = digit_start_reg[`VPSC_DS_DISP_BIT];

  // ****************************************
  // Pin selection
  // ****************************************
  logic [4:0] start_code;
  logic [4:0] first_digit;
  logic [4:0] last_digit;
  logic [4:0] digits_used;
  logic [4:0] first_shared_seg;
  logic seg_code_ok;
  logic seg_any;
  logic key_add;
  logic [4:0] frame_slots;
  logic [DIGITS-1:0] digit_valid;
  logic [SEGMENTS-1:0] seg_valid;

  // Start code below 8 splits the shared pins; 8 and above gives all to segments
  assign start_code = {1'b0, dual_pin_start_field};
  assign first_digit = dual_pin_start_field[3] ? `VPSC_SHARED_PINS : start_code;
  assign last_digit = `VPSC_DIGIT_LAST - {1'b0, digit_count_field}; // R1
  assign digits_used = (last_digit >= first_digit) ? 
                       (last_digit - first_digit + 5'd1) : 5'd0;
  // Shared pin k drives digit k or segment 7-k
  assign first_shared_seg = dual_pin_start_field[3] ? 5'd0 : (`VPSC_SHARED_PINS - start_code);
  assign seg_code_ok = (segment_count_field <= `VPSC_SEG_MAX_CODE); // R2
  assign seg_any = seg_code_ok && (segment_count_field >= first_shared_seg); // R9
  // Key slot only if the frame uses a digit and a segment
  assign key_add = key_scan_allow && (digits_used != 5'd0) && seg_any; // R8 R9
  assign frame_slots = digits_used + {4'd0, key_add}; // R13

  genvar gd;
  generate
    for (gd = 0; gd < DIGITS; gd++) begin : g_dvalid
      assign digit_valid[gd] = (5'(gd) >= first_digit) && (5'(gd) <= last_digit); // R1
    end
  endgenerate

  genvar gs;
  generate
    for (gs = 0; gs < SEGMENTS; gs++) begin : g_svalid
      assign seg_valid[gs] = seg_code_ok && (5'(gs) <= segment_count_field) && // R2
                             (5'(gs) >= first_shared_seg);
    end
  endgenerate

  // ****************************************
  // Frame sequencing
  // ****************************************
  logic [3:0] step;
  logic slot_end;
  logic [4:0] slot;
  logic [4:0] next_slot;
  logic key_scan;
  logic [4:0] cur_digit;

  vpsc_slot_timer u_timer (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .run_in(run && digits_used != 5'd0),
    .fast_in(scan_rate_select), // R12
    .step_out(step),
    .slot_end_out(slot_end)
  );

  assign next_slot = (slot + 5'd1 >= frame_slots) ? 5'd0 : slot + 5'd1; // R13

  // Slot moves one clock after the step wrap, inside blanked step 0
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      slot <= 5'd0;
    end else if (!run || digits_used == 5'd0) begin
      slot <= 5'd0;
    end else if (slot_end) begin
      slot <= next_slot;
    end
  end

  // Key slot follows the last digit slot
  assign key_scan = run && key_add && (slot == digits_used); // R8
  assign cur_digit = first_digit + slot;

  // ****************************************
  // Waveform windows in dimmer steps
  // ****************************************
  logic digit_window;
  logic seg_window;

  // Step 0 blanks both so segments change while all digits are off
  assign digit_window = (step != 4'd0) &&
                        ({1'b0, step} <= 5'd14 - {2'd0, digit_waveform_select}); // R11
  assign seg_window = (step != 4'd0); // R11

  // ****************************************
  // Pin outputs
  // ****************************************
  // Display flags follow the flag and pin settings, segment flags also the key slot; run gates the strobes and segment drive
  generate
    for (gd = 0; gd < DIGITS; gd++) begin : g_dout
      always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          digit_pin_display_out[gd] <= 1'b0;
          digit_output_out[gd] <= 1'b0;
        end else begin
          digit_pin_display_out[gd] <= pin_function_flag && digit_valid[gd]; // R5 R6
          digit_output_out[gd] <= pin_function_flag && digit_valid[gd] && run && // R6
                                  !key_scan && (cur_digit == 5'(gd)) && digit_window;
        end
      end
    end
  endgenerate

  generate
    for (gs = 0; gs < SEGMENTS; gs++) begin : g_sout
      always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          segment_pin_display_out[gs] <= 1'b0;
          segment_output_out[gs] <= 1'b0;
        end else begin
          segment_pin_display_out[gs] <= pin_function_flag && seg_valid[gs] && !key_scan; // R7
          segment_output_out[gs] <= pin_function_flag && seg_valid[gs] && !key_scan && // R6
                                    run && disp && seg_window && seg_data_in[gs];
        end
      end
    end
  endgenerate

  // Index keeps counting through the key slot; strobes stay off there
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      digit_index_out <= 4'd0;
      key_scan_out <= 1'b0;
    end else begin
      digit_index_out <= cur_digit[3:0];
      key_scan_out <= key_scan; // R8
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (rd_addr)
      `VPSC_OFS_DIGIT_CTRL: rd_word = {24'h0, digit_control_reg};
      `VPSC_OFS_SEG_CTRL: begin
        rd_word = {24'h0, pin_function_flag && !key_scan, // R7
                   key_scan_allow, 1'b1, segment_count_field}; // R4
      end
      `VPSC_OFS_DIGIT_START: rd_word = {24'h0, digit_start_reg[7:6], 1'b1,
                                        digit_start_reg[4:0]};
      // Status is read only; writes to it fall through
      `VPSC_OFS_STATUS: rd_word = {16'h0, 3'd0, digits_used, key_scan, 2'd0, slot};
      default: rd_word = 32'h0000_0000;
    endcase
  end
endmodule : vpsc_top
`default_nettype wire

// ===== dv/vpsc_checker.sv
// Port assertions for the pin select block
`default_nettype none
`include "vpsc_defs.svh"
module vpsc_checker #(
  parameter int DIGITS = 16,
  parameter int SEGMENTS = 28
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic hsel_in,
  input wire logic [7:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic hreadyout_out,
  input wire logic [31:0] hrdata_out,
  input wire logic [DIGITS-1:0] digit_output_out,
  input wire logic [DIGITS-1:0] digit_pin_display_out,
  input wire logic [SEGMENTS-1:0] segment_pin_display_out,
  input wire logic key_scan_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Shadow of the control fields
  // ****************************************
  logic wr_ph;
  logic [7:0] wa;
  logic flag;
  logic allow;
  logic [4:0] scode;
  logic [3:0] dcode;
  logic [11:0] ks_cnt;
  wire taken = hsel_in && htrans_in[1] && hready_in;
  wire rd_take = taken && !hwrite_in;
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ph <= 1'b0;
      wa <= 8'h00;
    end else if (hready_in) begin
      wr_ph <= taken && hwrite_in;
      wa <= haddr_in;
    end
  end
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      {flag, allow, scode} <= 7'h00;
      dcode <= 4'h0;
    end else if (wr_ph && hready_in) begin
      if (wa == `VPSC_OFS_SEG_CTRL) begin
        {flag, allow, scode} <= {hwdata_in[7:6], hwdata_in[4:0]};
      end
      if (wa == `VPSC_OFS_DIGIT_CTRL) begin
        dcode <= hwdata_in[3:0];
      end
    end
  end
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ks_cnt <= 12'h000;
    end else begin
      ks_cnt <= key_scan_out ? ks_cnt + 12'h001 : 12'h000;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  property p_read_wait;
    rd_take |=> !hreadyout_out ##1 (hreadyout_out && hrdata_out[31:8] == 24'h0);
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait or upper bits wrong");
  property p_write_nowait;
    taken && hwrite_in |=> hreadyout_out;
  endproperty
  a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
  property p_rsvd_one;
    rd_take && haddr_in == `VPSC_OFS_SEG_CTRL |-> ##2 hrdata_out[5];
  endproperty
  a_rsvd_one: assert property (p_rsvd_one) else $error("reserved bit read zero");
  property p_flag_off;
    !$past(flag) |-> digit_pin_display_out == '0 && segment_pin_display_out == '0;
  endproperty
  a_flag_off: assert property (p_flag_off) else $error("display pin while flag clear");
  property p_seg_none;
    $past(scode) > 5'd27 |-> segment_pin_display_out == '0;
  endproperty
  a_seg_none: assert property (p_seg_none) else $error("segment set on empty code");
  property p_digit_limit;
    (32'(digit_pin_display_out) >> (5'd16 - {1'b0, $past(dcode)})) == 32'h0;
  endproperty
  a_digit_limit: assert property (p_digit_limit) else $error("digit above count");
  property p_key_seg;
    key_scan_out ##1 key_scan_out ##1 key_scan_out |-> $past(segment_pin_display_out) == '0;
  endproperty
  a_key_seg: assert property (p_key_seg) else $error("segment pin in key scan");
  property p_key_dig;
    key_scan_out ##1 key_scan_out ##1 key_scan_out |-> $past(digit_output_out) == '0;
  endproperty
  a_key_dig: assert property (p_key_dig) else $error("digit strobe in key scan");
  property p_key_allow;
    $rose(key_scan_out) |-> $past(allow) || $past(allow, 2) || $past(allow, 3);
  endproperty
  a_key_allow: assert property (p_key_allow) else $error("key scan not allowed");
  property p_key_len;
    key_scan_out |-> ks_cnt < 12'd1536;
  endproperty
  a_key_len: assert property (p_key_len) else $error("key scan slot too long");
  c_read: cover property (rd_take);
  c_key: cover property ($rose(key_scan_out));
  c_pins: cover property (flag && digit_pin_display_out != '0);
endmodule : vpsc_checker
bind vpsc_top vpsc_checker #(.DIGITS(DIGITS), .SEGMENTS(SEGMENTS)) i_vpsc_checker (
  .core_clk_in(core_clk_in), .rstn_in(rstn_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
  .hreadyout_out(hreadyout_out), .hrdata_out(hrdata_out), .digit_output_out(digit_output_out),
  .digit_pin_display_out(digit_pin_display_out), .key_scan_out(key_scan_out),
  .segment_pin_display_out(segment_pin_display_out));
`default_nettype wire

// ===== dv/vpsc_tube_model.sv
// Behavioural tube: segment pattern of the digit being scanned
`default_nettype none
module vpsc_tube_model (
  input wire logic [3:0] digit_index_in,
  input wire logic [15:0] digit_output_in,
  output logic [27:0] seg_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pattern differs per digit and flips when no strobe is on
  assign seg_data_out = (digit_output_in == 16'h0) ? ~{7{digit_index_in}} :
    {7{digit_index_in}} ^ 28'h5a5a5a5;
endmodule : vpsc_tube_model
`default_nettype wire

// ===== dv/vpsc_top_bench.sv
// Self-checking bench of the pin select block
`default_nettype none
module vpsc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic hsel_in = 1'b0;
  logic [7:0] haddr_in = 8'h00;
  logic [1:0] htrans_in = 2'b00;
  logic hwrite_in = 1'b0;
  logic [31:0] hwdata_in = 32'h0;
  logic hreadyout_out;
  logic [31:0] hrdata_out;
  logic hresp;
  logic [27:0] seg_out;
  logic [27:0] seg_data;
  logic [3:0] dig_idx;
  logic [15:0] dig_out;
  logic [15:0] dig_pin;
  logic [27:0] seg_pin;
  logic key_scan;
  int err_count = 0;
  int n_checks = 0;
  logic [31:0] exp_q[$];
  logic rd_pend = 1'b0;
  logic ks_prev = 1'b0;
  int run_len = 0;
  int hi_len = 0;
  int lo_len = 0;
  always #25 core_clk_in = ~core_clk_in;
  vpsc_top i_vpsc_top (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'b010),
    .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hreadyout_out(hreadyout_out),
    .hrdata_out(hrdata_out), .hresp_out(hresp), .seg_data_in(seg_data), .digit_index_out(dig_idx),
    .digit_output_out(dig_out), .digit_pin_display_out(dig_pin), .segment_output_out(seg_out),
    .segment_pin_display_out(seg_pin), .key_scan_out(key_scan));
  vpsc_tube_model i_vpsc_tube_model (.digit_index_in(dig_idx), .digit_output_in(dig_out),
    .seg_data_out(seg_data));
  // ****************************************
  // Tasks
  // ****************************************
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    hsel_in <= 1'b1;
    haddr_in <= a;
    htrans_in <= 2'b10;
    hwrite_in <= w;
    do @(posedge core_clk_in); while (hreadyout_out !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'b00;
    hwdata_in <= {24'h0, d};
    do @(posedge core_clk_in); while (hreadyout_out !== 1'b1);
  endtask : bus
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 8'h00);
  endtask : rd
  task wait_key(input logic lv);
    do @(posedge core_clk_in); while (key_scan !== lv);
  endtask : wait_key
  task pins(input int c, input int n, input int b);
    logic [15:0] ed;
    logic [27:0] es;
    int lo;
    lo = (b >= 8) ? 0 : 8 - b;
    ed = '0;
    es = '0;
    for (int k = (b >= 8) ? 8 : b; k <= 15 - c; k++) ed[k] = 1'b1;
    for (int k = lo; k <= n && n <= 27; k++) es[k] = 1'b1;
    chk("digit pins", {16'h0, ed}, {16'h0, dig_pin});
    chk("segment pins", {4'h0, es}, {4'h0, seg_pin});
  endtask : pins
  // ****************************************
  // Watchers
  // ****************************************
  always @(posedge core_clk_in) begin
    if (rd_pend && hreadyout_out === 1'b1) chk("read data", exp_q.pop_front(), hrdata_out);
    if (hreadyout_out === 1'b1) rd_pend <= hsel_in && htrans_in[1] && !hwrite_in;
  end
  always @(posedge core_clk_in) begin
    if (key_scan === ks_prev) run_len++;
    else begin
      if (ks_prev) hi_len = run_len;
      else lo_len = run_len;
      run_len = 1;
    end
    ks_prev = key_scan;
  end
  initial begin
    #(60000 * 50);
    err_count++;
    give_verdict();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int c;
    int n;
    int b;
    int hits;
    logic [7:0] rv;
    void'($urandom(24526));
    repeat (20) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    @(posedge core_clk_in);
    rd(8'h00, 32'h00);
    rd(8'h04, 32'h20);
    rd(8'h10, 32'h00);
    chk("bus response", 32'h0, {31'h0, hresp});
    rv = 8'($urandom);
    bus(8'h00, 1'b1, rv);
    rd(8'h00, {24'h0, rv});
    for (int i = 0; i < 48; i++) begin
      c = i % 16;
      n = i % 32;
      b = $urandom % 16;
      rv = 8'($urandom);
      bus(8'h00, 1'b1, {rv[7:4], c[3:0]});
      bus(8'h08, 1'b1, {4'h0, b[3:0]});
      bus(8'h04, 1'b1, {1'b1, rv[0], 1'b0, n[4:0]});
      repeat (2) @(posedge core_clk_in);
      pins(c, n, b);
      rd(8'h04, {24'h0, 1'b1, rv[0], 1'b1, n[4:0]});
    end
    bus(8'h04, 1'b1, 8'h1b);
    repeat (2) @(posedge core_clk_in);
    chk("digit pins off", 32'h0, {16'h0, dig_pin});
    chk("segment pins off", 32'h0, {4'h0, seg_pin});
    for (int r = 0; r < 2; r++) begin
      bus(8'h00, 1'b1, {r[0], 7'h0e});
      bus(8'h08, 1'b1, 8'hc0);
      bus(8'h04, 1'b1, 8'hc9);
      wait_key(1'b1);
      rd(8'h04, 32'h69);
      chk("segment pins in key scan", 32'h0, {4'h0, seg_pin});
      chk("lit segments in key scan", 32'h0, {4'h0, seg_out});
      wait_key(1'b0);
      wait_key(1'b1);
      wait_key(1'b0);
      @(posedge core_clk_in);
      chk("key slot length", r ? 768 : 1536, hi_len);
      chk("frame gap length", r ? 1536 : 3072, lo_len);
      do @(posedge core_clk_in); while (dig_out[0] !== 1'b1);
      repeat (4) @(posedge core_clk_in);
      chk("lit segments", 32'h100, {4'h0, seg_out});
      hits = 4;
      do begin
        @(posedge core_clk_in);
        hits++;
      end while (dig_out[0] === 1'b1);
      chk("strobe length", r ? 672 : 1344, hits);
    end
    bus(8'h04, 1'b1, 8'h89);
    wait_key(1'b0);
    hits = 0;
    repeat (3000) begin
      @(posedge core_clk_in);
      if (key_scan !== 1'b0) hits++;
    end
    chk("key scan with allow clear", 32'h0, hits);
    rd(8'h04, 32'ha9);
    give_verdict();
  end
endmodule : vpsc_top_bench
`default_nettype wire
